/* File: logic/smb_pair_buf.sv */
// Two-entry buffer for received bytes
`timescale 1ns/10ps
module smb_pair_buf (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [7:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [7:0] out_data_o
);
   logic [7:0] mem_reg [2];
   logic wr_ptr_reg;
   logic rd_ptr_reg;
   logic [1:0] cnt_reg;
   logic push;
   logic pop;

   assign in_ready_o = cnt_reg != smb_pkg::BUF_FULL;
   assign out_valid_o = cnt_reg != smb_pkg::BUF_EMPTY;
   assign out_data_o = mem_reg[rd_ptr_reg];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   for (genvar i = 0; i < 2; i++) begin : g_entry
      always_ff @(posedge clk_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            mem_reg[i] <= smb_pkg::DAT_RST;
         end else if (push && wr_ptr_reg == 1'(i)) begin
            mem_reg[i] <= in_data_i;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         cnt_reg <= smb_pkg::BUF_EMPTY;
      end else begin
         if (push) begin
            wr_ptr_reg <= !wr_ptr_reg;
         end
         if (pop) begin
            rd_ptr_reg <= !rd_ptr_reg;
         end
         if (push && !pop) begin
            cnt_reg <= cnt_reg + 2'h1;
         end else if (pop && !push) begin
            cnt_reg <= cnt_reg - 2'h1;
         end
      end
   end
endmodule : smb_pair_buf

/* File: logic/smb_pkg.sv */
// Shared constants and state encoding for the serial transfer block
package smb_pkg;
   localparam int CLK_NS = 50;
   localparam int SCL_HALF_NS = 5000;
   localparam int HALF_CYC = (SCL_HALF_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [6:0] HALF_LAST = 7'(HALF_CYC - 1);
   localparam logic [6:0] HALF_ZERO = 7'h00;
   localparam logic [3:0] CNT_ZERO = 4'h0;
   localparam logic [3:0] CNT_LAST_DATA = 4'h7;
   localparam logic [3:0] CNT_ACK = 4'h8;
   localparam logic [1:0] STEP_ZERO = 2'h0;
   localparam logic [1:0] STEP_ONE = 2'h1;
   localparam logic [1:0] STEP_TWO = 2'h2;
   localparam logic [1:0] STEP_THREE = 2'h3;
   localparam logic [7:0] DAT_RST = 8'h00;
   localparam logic [3:0] VEC_M_START = 4'hE;
   localparam logic [3:0] VEC_S_TX_STOP = 4'h5;
   localparam logic [1:0] BUF_EMPTY = 2'h0;
   localparam logic [1:0] BUF_FULL = 2'h2;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_START = 3'b001,
      ST_BITS = 3'b010,
      ST_HOLD = 3'b011,
      ST_DECIDE = 3'b100,
      ST_STOP = 3'b101,
      ST_IGNORE = 3'b110,
      ST_PUSH = 3'b111
   } smb_state_e;
endpackage : smb_pkg

/* File: logic/smb_xfer.sv */
// Two-wire bus transfer sequencer with status vector and receive buffer
// Notes on behaviour
// - Master read: generate START, send address byte with read bit, clock SCL.
// - Master receiver sets ack request and interrupt before each ACK cycle.
// - Outgoing ACK follows software ack bit: 1 pulls SDA low, 0 NACKs.
// - Master receiver mode lasts until a STOP or repeated START is generated, or data is written.
// - Data write while master receiver turns next byte into transmit.
// - Uninhibited START plus matching write address: interrupt and ack request.
// - NACKed slave address suppresses slave interrupts until next START.
// - Data write while slave receiver switches to slave transmitter.
// - Matching read address interrupts; software then loads first byte.
// - After NACK, data write before interrupt clear is flagged as error.
// - No data write after slave transmit interrupt reverts to receiver.
// - Transmit interrupt after ACK cycle; receive interrupt before it.
// - Status vector is master, transmit, start and stop flags, high bits.
// - After master START the vector reads 1110, ack request clear.
// - NACKed master byte: start request restarts, stop request aborts.
// - ACKed master byte: data, STOP, STOP+START, repeated START or receive.
// - Received master byte: ack choice plus STOP or START; data write transmits.
// - Slave byte sent reports 0100 with ACK bit, or error as lost flag.
// - STOP seen as addressed slave transmitter reports 0101.
// - Bytes shift most significant bit first.
// - Master from generated START until arbitration loss or STOP.
`timescale 1ns/10ps
module smb_xfer (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic [6:0] own_addr_i,
   input wire logic slave_event_inhibit_i,
   input wire logic ctl_wr_i,
   input wire logic ctl_sta_i,
   input wire logic ctl_sto_i,
   input wire logic ctl_ack_i,
   input wire logic si_clr_i,
   input wire logic dat_wr_i,
   input wire logic [7:0] dat_i,
   output logic [7:0] bus_shift_data_o,
   output logic [7:0] bus_control_status_o,
   output logic rx_valid_o,
   input wire logic rx_ready_i,
   output logic [7:0] rx_data_o
);
   smb_pkg::smb_state_e state_reg;
   logic scl_meta_reg, scl_sync_reg, scl_prev_reg;
   logic sda_meta_reg, sda_sync_reg, sda_prev_reg;
   logic [6:0] half_cnt_reg;
   logic [3:0] bit_cnt_reg;
   logic [1:0] step_reg;
   logic [7:0] shift_reg;
   logic master_reg, tx_dir_reg, sta_reg, sto_reg;
   logic ack_request_reg, arb_lost_reg, ack_reg, si_reg;
   logic addr_phase_reg, addressed_reg, suppress_reg;
   logic dat_pend_reg, err_pend_reg, push_reg;
   logic sda_low_reg, scl_low_reg, zero_reg;
   logic scl_rise, scl_fall, start_det, stop_det;
   logic tick_run, scl_wait, tick, buf_ready, addr_hit;

   assign scl_rise = scl_sync_reg && !scl_prev_reg;
   assign scl_fall = !scl_sync_reg && scl_prev_reg;
   assign start_det = scl_sync_reg && scl_prev_reg && sda_prev_reg
      && !sda_sync_reg;
   assign stop_det = scl_sync_reg && scl_prev_reg && !sda_prev_reg
      && sda_sync_reg;
   assign tick_run = master_reg && (state_reg == smb_pkg::ST_BITS
      || state_reg == smb_pkg::ST_START || state_reg == smb_pkg::ST_STOP);
   // Clock synchronisation: a released SCL still held low stalls the count
   assign scl_wait = !scl_low_reg && !scl_sync_reg;
   assign tick = tick_run && !scl_wait && half_cnt_reg == smb_pkg::HALF_LAST;
   assign addr_hit = shift_reg[7:1] == own_addr_i && !slave_event_inhibit_i
      && !suppress_reg;

   assign scl_o = zero_reg;
   assign sda_o = zero_reg;
   assign scl_oe_o = scl_low_reg;
   assign sda_oe_o = sda_low_reg;
   assign bus_shift_data_o = shift_reg;
   assign bus_control_status_o = {master_reg, tx_dir_reg, sta_reg, sto_reg,
      ack_request_reg, arb_lost_reg, ack_reg, si_reg};

   // Pin synchronisers and edge history
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         scl_meta_reg <= 1'b1;
         scl_sync_reg <= 1'b1;
         scl_prev_reg <= 1'b1;
         sda_meta_reg <= 1'b1;
         sda_sync_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
         zero_reg <= 1'b0;
      end else begin
         scl_meta_reg <= scl_i;
         scl_sync_reg <= scl_meta_reg;
         scl_prev_reg <= scl_sync_reg;
         sda_meta_reg <= sda_i;
         sda_sync_reg <= sda_meta_reg;
         sda_prev_reg <= sda_sync_reg;
         zero_reg <= 1'b0;
      end
   end

   // Half-period timer for the generated clock and START/STOP steps
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         half_cnt_reg <= smb_pkg::HALF_ZERO;
      end else if (!tick_run || tick) begin
         half_cnt_reg <= smb_pkg::HALF_ZERO;
      end else if (!scl_wait) begin
         half_cnt_reg <= half_cnt_reg + 7'h01;
      end
   end

   // Transfer sequencer and software-visible flags
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= smb_pkg::ST_IDLE;
         bit_cnt_reg <= smb_pkg::CNT_ZERO;
         step_reg <= smb_pkg::STEP_ZERO;
         shift_reg <= smb_pkg::DAT_RST;
         master_reg <= 1'b0;
         tx_dir_reg <= 1'b0;
         sta_reg <= 1'b0;
         sto_reg <= 1'b0;
         ack_request_reg <= 1'b0;
         arb_lost_reg <= 1'b0;
         ack_reg <= 1'b0;
         si_reg <= 1'b0;
         addr_phase_reg <= 1'b0;
         addressed_reg <= 1'b0;
         suppress_reg <= 1'b0;
         dat_pend_reg <= 1'b0;
         err_pend_reg <= 1'b0;
         push_reg <= 1'b0;
         sda_low_reg <= 1'b0;
         scl_low_reg <= 1'b0;
      end else begin
         push_reg <= 1'b0;
         if (ctl_wr_i) begin
            sta_reg <= ctl_sta_i;
            sto_reg <= ctl_sto_i;
            ack_reg <= ctl_ack_i;
         end
         // Only software clears the flag; any hardware set below wins
         if (si_clr_i) begin
            si_reg <= 1'b0;
            arb_lost_reg <= 1'b0;
         end
         if (dat_wr_i && si_reg) begin
            shift_reg <= dat_i;
            dat_pend_reg <= 1'b1;
            if (!master_reg && tx_dir_reg && !ack_reg) begin
               err_pend_reg <= 1'b1;
            end
         end
         if (master_reg && state_reg == smb_pkg::ST_BITS && tick) begin
            scl_low_reg <= !scl_low_reg;
         end
         unique case (state_reg)
            smb_pkg::ST_IDLE: begin
               if (sta_reg && !si_reg && scl_sync_reg && sda_sync_reg) begin
                  state_reg <= smb_pkg::ST_START;
                  step_reg <= smb_pkg::STEP_ZERO;
                  master_reg <= 1'b1;
               end
            end
            smb_pkg::ST_START: begin
               if (tick) begin
                  step_reg <= step_reg + 2'h1;
                  unique case (step_reg)
                     smb_pkg::STEP_ZERO: sda_low_reg <= 1'b0;
                     smb_pkg::STEP_ONE: scl_low_reg <= 1'b0;
                     smb_pkg::STEP_TWO: sda_low_reg <= 1'b1;
                     smb_pkg::STEP_THREE: begin
                        scl_low_reg <= 1'b1;
                        si_reg <= 1'b1;
                        tx_dir_reg <= 1'b1;
                        ack_request_reg <= 1'b0;
                        arb_lost_reg <= 1'b0;
                        dat_pend_reg <= 1'b0;
                        bit_cnt_reg <= smb_pkg::CNT_ACK;
                        state_reg <= smb_pkg::ST_HOLD;
                     end
                  endcase
               end
            end
            smb_pkg::ST_BITS: begin
               if (scl_rise && bit_cnt_reg != smb_pkg::CNT_ACK) begin
                  shift_reg <= {shift_reg[6:0], sda_sync_reg};
                  if (tx_dir_reg && !sda_low_reg && !sda_sync_reg) begin
                     if (master_reg) begin
                        arb_lost_reg <= 1'b1;
                        master_reg <= 1'b0;
                        tx_dir_reg <= 1'b0;
                        si_reg <= 1'b1;
                        sda_low_reg <= 1'b0;
                        scl_low_reg <= 1'b0;
                        state_reg <= smb_pkg::ST_IGNORE;
                     end else begin
                        err_pend_reg <= 1'b1;
                     end
                  end
               end
               if (scl_rise && bit_cnt_reg == smb_pkg::CNT_ACK
                  && tx_dir_reg) begin
                  ack_reg <= !sda_sync_reg;
               end
               // The SCL fall that ends a detected START carries no bit
               if (scl_fall && step_reg == smb_pkg::STEP_ONE) begin
                  step_reg <= smb_pkg::STEP_ZERO;
               end else if (scl_fall
                  && bit_cnt_reg < smb_pkg::CNT_LAST_DATA) begin
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  sda_low_reg <= tx_dir_reg && !shift_reg[7];
               end else if (scl_fall
                  && bit_cnt_reg == smb_pkg::CNT_LAST_DATA) begin
                  // A master keeps SCL low for the half period before ack
                  scl_low_reg <= master_reg || !tx_dir_reg;
                  if (tx_dir_reg) begin
                     bit_cnt_reg <= smb_pkg::CNT_ACK;
                     sda_low_reg <= 1'b0;
                  end else if (!addr_phase_reg) begin
                     state_reg <= smb_pkg::ST_PUSH;
                  end else if (addr_hit) begin
                     addressed_reg <= 1'b1;
                     sta_reg <= 1'b1;
                     si_reg <= 1'b1;
                     ack_request_reg <= 1'b1;
                     state_reg <= smb_pkg::ST_HOLD;
                  end else begin
                     scl_low_reg <= 1'b0;
                     state_reg <= smb_pkg::ST_IGNORE;
                  end
               end else if (scl_fall) begin
                  ack_request_reg <= 1'b0;
                  sda_low_reg <= 1'b0;
                  scl_low_reg <= 1'b1;
                  addr_phase_reg <= 1'b0;
                  if (tx_dir_reg) begin
                     si_reg <= 1'b1;
                     arb_lost_reg <= err_pend_reg && !master_reg;
                     err_pend_reg <= 1'b0;
                     state_reg <= smb_pkg::ST_HOLD;
                  end else if (addr_phase_reg && !ack_reg) begin
                     suppress_reg <= 1'b1;
                     addressed_reg <= 1'b0;
                     scl_low_reg <= 1'b0;
                     state_reg <= smb_pkg::ST_IGNORE;
                  end else begin
                     state_reg <= smb_pkg::ST_DECIDE;
                  end
               end
            end
            smb_pkg::ST_PUSH: begin
               // Receiver stall stretches SCL instead of dropping a byte
               if (buf_ready) begin
                  push_reg <= 1'b1;
                  si_reg <= 1'b1;
                  ack_request_reg <= 1'b1;
                  state_reg <= smb_pkg::ST_HOLD;
               end
            end
            smb_pkg::ST_HOLD: begin
               scl_low_reg <= 1'b1;
               if (!si_reg) begin
                  if (bit_cnt_reg == smb_pkg::CNT_LAST_DATA) begin
                     bit_cnt_reg <= smb_pkg::CNT_ACK;
                     sda_low_reg <= ack_reg;
                     scl_low_reg <= master_reg;
                     state_reg <= smb_pkg::ST_BITS;
                  end else begin
                     state_reg <= smb_pkg::ST_DECIDE;
                  end
               end
            end
            smb_pkg::ST_DECIDE: begin
               bit_cnt_reg <= smb_pkg::CNT_ZERO;
               dat_pend_reg <= 1'b0;
               step_reg <= smb_pkg::STEP_ZERO;
               if (master_reg && sto_reg) begin
                  state_reg <= smb_pkg::ST_STOP;
               end else if (master_reg && sta_reg) begin
                  state_reg <= smb_pkg::ST_START;
               end else begin
                  tx_dir_reg <= dat_pend_reg;
                  sda_low_reg <= dat_pend_reg && !shift_reg[7];
                  scl_low_reg <= master_reg;
                  state_reg <= smb_pkg::ST_BITS;
               end
            end
            smb_pkg::ST_STOP: begin
               if (tick) begin
                  step_reg <= step_reg + 2'h1;
                  if (step_reg == smb_pkg::STEP_ZERO) begin
                     sda_low_reg <= 1'b1;
                     scl_low_reg <= 1'b1;
                  end else if (step_reg == smb_pkg::STEP_ONE) begin
                     scl_low_reg <= 1'b0;
                  end else begin
                     sda_low_reg <= 1'b0;
                     master_reg <= 1'b0;
                     sto_reg <= 1'b0;
                     tx_dir_reg <= 1'b0;
                     state_reg <= smb_pkg::ST_IDLE;
                  end
               end
            end
            smb_pkg::ST_IGNORE: begin
               sda_low_reg <= 1'b0;
               scl_low_reg <= 1'b0;
            end
         endcase
         if (start_det && !master_reg) begin
            suppress_reg <= 1'b0;
            addr_phase_reg <= 1'b1;
            tx_dir_reg <= 1'b0;
            bit_cnt_reg <= smb_pkg::CNT_ZERO;
            sda_low_reg <= 1'b0;
            scl_low_reg <= 1'b0;
            step_reg <= smb_pkg::STEP_ONE;
            state_reg <= smb_pkg::ST_BITS;
         end else if (stop_det && !master_reg) begin
            if (addressed_reg) begin
               sto_reg <= 1'b1;
               si_reg <= 1'b1;
            end
            addressed_reg <= 1'b0;
            ack_request_reg <= 1'b0;
            sda_low_reg <= 1'b0;
            scl_low_reg <= 1'b0;
            state_reg <= smb_pkg::ST_IDLE;
         end
      end
   end

   smb_pair_buf u_buf (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .in_valid_i(push_reg),
      .in_ready_o(buf_ready),
      .in_data_i(shift_reg),
      .out_valid_o(rx_valid_o),
      .out_ready_i(rx_ready_i),
      .out_data_o(rx_data_o)
   );

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence s_rx_ack_cycle;
      state_reg == smb_pkg::ST_BITS && bit_cnt_reg == smb_pkg::CNT_ACK
         && !tx_dir_reg;
   endsequence
   sequence s_hold_wait;
      (state_reg == smb_pkg::ST_HOLD && si_reg) [*2];
   endsequence

   AST_ACK_DRIVE: assert property (s_rx_ack_cycle |-> sda_low_reg == ack_reg)
      else $error("ack drive differs from ack bit");
   AST_RX_SI_BEFORE_ACK: assert property (
      (state_reg == smb_pkg::ST_PUSH && buf_ready) |=>
         si_reg && ack_request_reg && bit_cnt_reg == smb_pkg::CNT_LAST_DATA)
      else $error("receive interrupt not before ack");
   AST_TX_SI_AFTER_ACK: assert property (
      (state_reg == smb_pkg::ST_BITS && bit_cnt_reg == smb_pkg::CNT_ACK
         && tx_dir_reg && scl_fall && !stop_det && !start_det) |=>
         si_reg && state_reg == smb_pkg::ST_HOLD)
      else $error("transmit interrupt not after ack");
   AST_START_VEC: assert property (
      (state_reg == smb_pkg::ST_START && step_reg == smb_pkg::STEP_THREE
         && tick && sta_reg && !sto_reg && !ctl_wr_i) |=>
         bus_control_status_o[7:4] == smb_pkg::VEC_M_START
         && !ack_request_reg && !arb_lost_reg)
      else $error("wrong vector after start");
   AST_SUPPRESS: assert property (
      (suppress_reg && !master_reg && !start_det) |=> !$rose(ack_request_reg))
      else $error("slave event while suppressed");
   AST_STOP_SLAVE_TX: assert property (
      (stop_det && !master_reg && addressed_reg && tx_dir_reg && !ctl_wr_i) |=>
         bus_control_status_o[7:4] == smb_pkg::VEC_S_TX_STOP
         && !ack_request_reg && si_reg)
      else $error("wrong vector on stop");
   AST_MASTER_HOLD: assert property (
      (master_reg && state_reg != smb_pkg::ST_STOP
         && state_reg != smb_pkg::ST_BITS) |=> master_reg)
      else $error("master dropped early");
   AST_STRETCH: assert property (s_hold_wait |-> scl_low_reg)
      else $error("clock released while flag set");
   AST_MODE_SWITCH: assert property (
      (state_reg == smb_pkg::ST_DECIDE && !(master_reg && (sto_reg || sta_reg)))
         |=> tx_dir_reg == $past(dat_pend_reg))
      else $error("mode switch ignores data write");
   AST_MSB_FIRST: assert property (
      (state_reg == smb_pkg::ST_BITS && tx_dir_reg && scl_fall && !scl_rise
         && bit_cnt_reg < smb_pkg::CNT_LAST_DATA && !start_det) |=>
         sda_low_reg == !$past(shift_reg[7]))
      else $error("bit order wrong");
endmodule : smb_xfer

/* File: test/smb_slave_model.sv */
// Remote slave that answers one address and returns one byte on a read
`timescale 1ns/10ps
module smb_slave_model #(
   parameter logic [6:0] ADDR = 7'h3B
) (
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_oe_o,
   input wire logic [7:0] tx_byte_i,
   output logic master_ack_o
);
   logic [7:0] sh;
   int i;
   initial begin
      sda_oe_o = 1'h0;
      master_ack_o = 1'h0;
      sh = 8'h00;
      forever begin
         @(negedge sda_i iff scl_i);
         for (i = 0; i < 8; i++) begin
            @(posedge scl_i);
            sh = {sh[6:0], sda_i};
         end
         @(negedge scl_i);
         if (sh[7:1] == ADDR) begin
            #100;
            sda_oe_o = 1'h1;
            @(negedge scl_i);
            #100;
            if (sh[0]) begin
               // Read: data bits MSB first, then hand SDA back for the ack
               for (i = 7; i >= 0; i--) begin
                  sda_oe_o = ~tx_byte_i[i];
                  @(negedge scl_i);
                  #100;
               end
               sda_oe_o = 1'h0;
               @(posedge scl_i);
               master_ack_o = ~sda_i;
            end else begin
               sda_oe_o = 1'h0;
            end
         end
      end
   end
endmodule : smb_slave_model

/* File: test/smb_xfer_tb_top.sv */
// Self-checking bench for the transfer sequencer as master and slave
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
   miscompares++; $display("unexpected %s exp %h got %h", n, e, g); end end
module smb_xfer_tb_top;
   localparam logic [6:0] SLV = 7'h3B;
   logic clk_i, rst_n_i, scl_oe, sda_oe, m_sda_oe, scl_w, sda_w;
   logic ctl_wr, start_request_flag, stop_request_flag, ack, si_clr, dat_wr, rx_ready, m_ack, rx_valid;
   logic slave_event_inhibit;
   logic r_scl_oe, r_sda_oe;
   logic [6:0] own;
   logic [7:0] dat, sdat, st, rx_data, tx_byte;
   int miscompares = 0;
   int checks_done = 0;
   assign scl_w = ~(scl_oe | r_scl_oe);
   assign sda_w = ~(sda_oe | m_sda_oe | r_sda_oe);
   smb_xfer u_smb_xfer (.clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl_w),
      .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(),
      .sda_oe_o(sda_oe), .own_addr_i(own), .slave_event_inhibit_i(slave_event_inhibit),
      .ctl_wr_i(ctl_wr), .ctl_sta_i(start_request_flag), .ctl_sto_i(stop_request_flag), .ctl_ack_i(ack),
      .si_clr_i(si_clr), .dat_wr_i(dat_wr), .dat_i(dat),
      .bus_shift_data_o(sdat), .bus_control_status_o(st),
      .rx_valid_o(rx_valid), .rx_ready_i(rx_ready), .rx_data_o(rx_data));
   smb_slave_model #(.ADDR(SLV)) u_smb_slave_model (.scl_i(scl_w),
      .sda_i(sda_w), .sda_oe_o(m_sda_oe), .tx_byte_i(tx_byte),
      .master_ack_o(m_ack));
   initial begin
      clk_i = 1'h0;
      forever #25 clk_i = ~clk_i;
   end
   task automatic close_out();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : close_out
   task automatic pulse_ctl(input logic a, input logic b, input logic c);
      @(posedge clk_i);
      {ctl_wr, start_request_flag, stop_request_flag, ack} <= {1'h1, a, b, c};
      @(posedge clk_i);
      ctl_wr <= 1'h0;
      @(negedge clk_i);
   endtask : pulse_ctl
   task automatic clr_si();
      @(posedge clk_i);
      si_clr <= 1'h1;
      @(posedge clk_i);
      si_clr <= 1'h0;
      @(negedge clk_i);
   endtask : clr_si
   task automatic wr_dat(input logic [7:0] d);
      @(posedge clk_i);
      {dat_wr, dat} <= {1'h1, d};
      @(posedge clk_i);
      dat_wr <= 1'h0;
      @(negedge clk_i);
   endtask : wr_dat
   task automatic wait_si();
      int n;
      n = 0;
      while (st[0] !== 1'h1 && n < 5000) begin
         @(negedge clk_i);
         n++;
      end
      `CHK("interrupt", 1'h1, st[0])
   endtask : wait_si
   // One master read, or a missed address when hit is low
   task automatic xfer(input logic hit);
      logic r;
      tx_byte = 8'($urandom);
      r = 1'($urandom);
      pulse_ctl(1'h1, 1'h0, 1'h1);
      wait_si();
      `CHK("start", 8'hE1, {st[7:2], 1'h0, st[0]})
      pulse_ctl(1'h0, 1'h0, 1'h1);
      wr_dat({SLV ^ {6'h00, ~hit}, 1'h1});
      clr_si();
      wait_si();
      `CHK("address", {4'hC, 2'h0, hit}, st[7:1])
      if (hit) begin
         clr_si();
         wait_si();
         `CHK("rx vector", 5'h11, st[7:3])
         `CHK("rx data", tx_byte, sdat)
         @(negedge clk_i);
         `CHK("rx stream", {1'h1, tx_byte}, {rx_valid, rx_data})
         @(posedge clk_i);
         rx_ready <= 1'h1;
         @(posedge clk_i);
         rx_ready <= 1'h0;
         @(negedge clk_i);
         `CHK("rx drained", 1'h0, rx_valid)
         pulse_ctl(1'h0, 1'h0, r);
         wr_dat(8'hA5);
         clr_si();
         wait_si();
         `CHK("tx switch", 1'h1, st[6])
         `CHK("master ack", r, m_ack)
         `CHK("tx nack", 5'h18, {st[7:4], st[1]})
      end
      pulse_ctl(1'h0, 1'h1, 1'h0);
      clr_si();
      repeat (400) @(negedge clk_i);
      `CHK("stop", 6'h03, {st[7:4], scl_w, sda_w})
   endtask : xfer
   // Remote master: one bit on the bench link clock, SCL low on entry
   task automatic rbit(input logic b, output logic s);
      @(posedge clk_i);
      r_sda_oe <= !b;
      repeat (3) @(posedge clk_i);
      r_scl_oe <= 1'h0;
      @(posedge clk_i iff scl_w);
      repeat (3) @(posedge clk_i);
      s = sda_w;
      r_scl_oe <= 1'h1;
   endtask : rbit
   // Remote master writes one byte to this block as an addressed slave
   task automatic slave_rx();
      logic [7:0] x, d;
      logic r, a0, a1;
      x = {own, 1'h0};
      d = 8'($urandom);
      r = 1'($urandom);
      fork
         begin
            @(posedge clk_i);
            {slave_event_inhibit, r_sda_oe} <= 2'h1;
            repeat (4) @(posedge clk_i);
            r_scl_oe <= 1'h1;
            for (int i = 7; i >= 0; i--) begin
               rbit(x[i], a0);
            end
            rbit(1'h1, a0);
            for (int i = 7; i >= 0; i--) begin
               rbit(d[i], a1);
            end
            rbit(1'h1, a1);
            @(posedge clk_i);
            r_sda_oe <= 1'h1;
            repeat (3) @(posedge clk_i);
            r_scl_oe <= 1'h0;
            repeat (4) @(posedge clk_i);
            r_sda_oe <= 1'h0;
         end
         begin
            wait_si();
            `CHK("slave addr", 6'h0A, st[7:2])
            pulse_ctl(1'h0, 1'h0, 1'h1);
            clr_si();
            wait_si();
            `CHK("slave byte", {6'h02, d}, {st[7:2], sdat})
            pulse_ctl(1'h0, 1'h0, r);
            clr_si();
            wait_si();
            `CHK("slave stop", 5'h02, {st[7:4], st[3]})
         end
      join
      `CHK("slave addr ack", 1'h0, a0)
      `CHK("slave byte ack", !r, a1)
      pulse_ctl(1'h0, 1'h0, 1'h0);
      clr_si();
   endtask : slave_rx
   initial begin
      {rst_n_i, ctl_wr, start_request_flag, stop_request_flag, ack, si_clr, dat_wr, rx_ready} = 8'h00;
      {r_scl_oe, r_sda_oe} = 2'h0;
      dat = 8'h00;
      tx_byte = 8'h00;
      slave_event_inhibit = 1'h1;
      void'($urandom(32'h1D5EB0E8));
      own = 7'($urandom) | 7'h40;
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'h1;
      @(negedge clk_i);
      `CHK("reset status", 8'h00, st)
      for (int k = 0; k < 3; k++) begin
         xfer(k != 1);
         $display("test %0d done", k);
      end
      slave_rx();
      $display("test 3 done");
      close_out();
   end
   initial begin
      #3000000;
      miscompares++;
      close_out();
   end
endmodule : smb_xfer_tb_top
